// File: common/ufbc_pkg.sv
// ufbc_pkg: register map, field positions, reset values, states and
// small helpers shared by the frame/baud configuration block.
// assumes a 32-bit apb register bus and one 10 mhz system clock.
package ufbc_pkg;

  localparam int          ADDR_W          = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_FRAME_FMT   = 8'h00;
  localparam logic [7:0]  OFS_BAUD_HIGH   = 8'h04;
  localparam logic [7:0]  OFS_BAUD_LOW    = 8'h08;
  localparam logic [7:0]  OFS_PORT_CTRL   = 8'h0C;
  localparam logic [7:0]  OFS_TX_DATA     = 8'h10;
  localparam logic [7:0]  OFS_RX_DATA     = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STAT    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_CLR     = 8'h1C;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h20;
  localparam logic [7:0]  OFS_PORT_STAT   = 8'h24;

  // frame_format_control fields
  localparam int          FFC_SYNC_BIT    = 6;
  localparam int          FFC_PAR_EN_BIT  = 5;
  localparam int          FFC_PAR_ODD_BIT = 4;
  localparam int          FFC_STOP_BIT    = 3;
  localparam int          FFC_CSZ_MID_BIT = 2;
  localparam int          FFC_CSZ_LOW_BIT = 1;
  localparam int          FFC_POL_BIT     = 0;
  localparam logic [7:0]  FFC_WMASK       = 8'h7F;
  localparam logic [7:0]  FFC_RESET       = 8'h06;

  // port_control_register fields
  localparam int          PCR_DBL_BIT     = 0;
  localparam int          PCR_CSZ_TOP_BIT = 1;
  localparam int          PCR_TX_EN_BIT   = 2;
  localparam int          PCR_RX_EN_BIT   = 3;
  localparam logic [7:0]  PCR_WMASK       = 8'h0F;
  localparam logic [7:0]  PCR_RESET       = 8'h00;

  localparam logic [7:0]  BDH_WMASK       = 8'h0F;
  localparam logic [11:0] BAUD_RESET      = 12'h000;

  // interrupt status / enable / clear layout
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_TX_DONE     = 0;
  localparam int          IRQ_RX_DONE     = 1;
  localparam int          IRQ_PAR_ERR     = 2;
  localparam int          IRQ_FRM_ERR     = 3;

  // oversampling: 16 per bit, 8 with double speed
  localparam logic [3:0]  OS_NORM_MAX     = 4'hF;
  localparam logic [3:0]  OS_DBL_MAX      = 4'h7;
  localparam logic [3:0]  OS_NORM_MID     = 4'h7;
  localparam logic [3:0]  OS_DBL_MID      = 4'h3;

  localparam logic [3:0]  MAX_BITS        = 4'h9;

  typedef enum logic [5:0] {
    UFBC_TX_IDLE  = 6'b000001,
    UFBC_TX_WAIT  = 6'b000010,
    UFBC_TX_START = 6'b000100,
    UFBC_TX_DATA  = 6'b001000,
    UFBC_TX_PAR   = 6'b010000,
    UFBC_TX_STOP  = 6'b100000
  } ufbc_tx_state_type;

  typedef enum logic [4:0] {
    UFBC_RX_IDLE  = 5'b00001,
    UFBC_RX_START = 5'b00010,
    UFBC_RX_DATA  = 5'b00100,
    UFBC_RX_PAR   = 5'b01000,
    UFBC_RX_STOP  = 5'b10000
  } ufbc_rx_state_type;

  // data bits per character; reserved codes fall back to 8
  function automatic logic [3:0] ufbc_nbits(input logic [2:0] code);
    case (code)
      3'h0:    ufbc_nbits = 4'h5;
      3'h1:    ufbc_nbits = 4'h6;
      3'h2:    ufbc_nbits = 4'h7;
      3'h7:    ufbc_nbits = 4'h9;
      default: ufbc_nbits = 4'h8;
    endcase
  endfunction : ufbc_nbits

  function automatic logic [8:0] ufbc_mask(input logic [3:0] n);
    ufbc_mask = 9'h1FF >> (MAX_BITS - n);
  endfunction : ufbc_mask

endpackage : ufbc_pkg

// File: hw/ufbc_baud_gen.sv
// ufbc_baud_gen: 12-bit baud prescaler, one tick every divisor+1 clocks.
// assumes reload is a one-cycle pulse from the register write decode.
`timescale 1ns/1ns
module ufbc_baud_gen
  import ufbc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // divisor control
  input  wire logic [11:0] divisor_i,
  input  wire logic        reload_i,
  // oversample tick
  output logic             tick_o
);

  logic [11:0] cnt_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= BAUD_RESET;
      tick_o <= 1'b0;
    end else if (reload_i) begin
      cnt_q  <= divisor_i;
      tick_o <= 1'b0;
    end else if (cnt_q == 12'h000) begin
      cnt_q  <= divisor_i;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - 12'h001;
      tick_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_reload_loads: assert property (
    reload_i |=> (cnt_q == $past(divisor_i)) && !tick_o)
    else $error("prescaler not reloaded by low divisor write");

  a_tick_spacing: assert property (
    (tick_o && divisor_i == 12'h003 && !reload_i) ##1
    (!reload_i && $stable(divisor_i)) [*3]
    |=> tick_o)
    else $error("prescaler tick spacing wrong");

endmodule : ufbc_baud_gen

// File: hw/ufbc_core.sv
// ufbc_core: usart frame format and baud configuration with a small
// transmitter and receiver that honour it, behind an apb slave.
// assumes rxd is synchronous to CLK_I; transfer clock is driven out.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
module ufbc_core
  import ufbc_pkg::*;
(
  // clock and reset
  input  wire logic                     CLK_I,
  input  wire logic                     RSTN_I,
  // apb slave
  input  wire logic                     PSEL_I,
  input  wire logic                     PENABLE_I,
  input  wire logic                     PWRITE_I,
  input  wire logic [ufbc_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]              PWDATA_I,
  output logic      [31:0]              PRDATA_O,
  output logic                          PREADY_O,
  output logic                          PSLVERR_O,
  // serial pins
  input  wire logic                     RXD_I,
  output logic                          TXD_O,
  output logic                          XCK_O,
  output logic                          XCK_OE_O,
  // interrupt
  output logic                          IRQ_O
);

  logic [7:0]        ffc_q;
  logic [7:0]        pcr_q;
  logic [3:0]        bdh_q;
  logic [7:0]        bdl_q;
  logic [IRQ_W-1:0]  stat_q;
  logic [IRQ_W-1:0]  irq_en_q;
  logic [8:0]        rx_data_q;
  logic              xck_q;
  logic              tick;
  logic              acc;
  logic              wr;
  logic              reload;
  logic              tx_load;
  logic              sync_mode;
  logic              par_on;
  logic              par_odd;
  logic              stop2;
  logic [3:0]        os_max;
  logic [3:0]        os_mid;
  logic [3:0]        nbits;
  logic              launch;
  logic              sample;
  logic              tx_bit;
  logic              rx_samp;
  logic              rx_go;
  logic [IRQ_W-1:0]  ev;
  logic [31:0]       rdata;
  logic              mapped;

  ufbc_tx_state_type tx_st_q;
  logic [8:0]        tx_sh_q;
  logic              tx_par_q;
  logic [3:0]        tx_idx_q;
  logic [3:0]        tx_cnt_q;
  logic              tx_stop_q;
  logic              tx_done_q;

  ufbc_rx_state_type rx_st_q;
  logic [8:0]        rx_sh_q;
  logic              rx_par_q;
  logic [3:0]        rx_idx_q;
  logic [3:0]        rx_cnt_q;
  logic              rx_done_q;
  logic              perr_q;
  logic              ferr_q;

  // ---------------- apb slave ----------------
  assign acc = PSEL_I & PENABLE_I & PREADY_O;
  assign wr  = acc & PWRITE_I;

  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR_I)
      OFS_FRAME_FMT: rdata[7:0] = ffc_q;
      OFS_BAUD_HIGH: rdata[3:0] = bdh_q;
      OFS_BAUD_LOW:  rdata[7:0] = bdl_q;
      OFS_PORT_CTRL: rdata[7:0] = pcr_q;
      OFS_TX_DATA:   rdata      = 32'h0000_0000;
      OFS_RX_DATA:   rdata[8:0] = rx_data_q;
      OFS_IRQ_STAT:  rdata[IRQ_W-1:0] = stat_q;
      OFS_IRQ_CLR:   rdata      = 32'h0000_0000;
      OFS_IRQ_EN:    rdata[IRQ_W-1:0] = irq_en_q;
      OFS_PORT_STAT: rdata[1:0] = {rx_st_q != UFBC_RX_IDLE,
                                   tx_st_q != UFBC_TX_IDLE};
      default:       mapped     = 1'b0;
    endcase
  end

  // zero-wait answer: ready in the first access cycle
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~mapped;
      if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
        PRDATA_O <= rdata;
      end
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ffc_q <= FFC_RESET;
      pcr_q <= PCR_RESET;
      bdh_q <= BAUD_RESET[11:8];
      bdl_q <= BAUD_RESET[7:0];
    end else if (wr) begin
      case (PADDR_I)
        OFS_FRAME_FMT: ffc_q <= PWDATA_I[7:0] & FFC_WMASK;
        OFS_PORT_CTRL: pcr_q <= PWDATA_I[7:0] & PCR_WMASK;
        OFS_BAUD_HIGH: bdh_q <= PWDATA_I[3:0];
        OFS_BAUD_LOW:  bdl_q <= PWDATA_I[7:0];
        default:       ;
      endcase
    end
  end

  assign reload  = wr & (PADDR_I == OFS_BAUD_LOW);
  assign tx_load = wr & (PADDR_I == OFS_TX_DATA) &
                   (tx_st_q == UFBC_TX_IDLE) & pcr_q[PCR_TX_EN_BIT];

  assign sync_mode = ffc_q[FFC_SYNC_BIT];
  assign par_on    = ffc_q[FFC_PAR_EN_BIT];
  assign par_odd   = ffc_q[FFC_PAR_ODD_BIT];
  assign stop2     = ffc_q[FFC_STOP_BIT];
  assign nbits     = ufbc_nbits({pcr_q[PCR_CSZ_TOP_BIT],
                                 ffc_q[FFC_CSZ_MID_BIT],
                                 ffc_q[FFC_CSZ_LOW_BIT]});
  // double speed only counts in asynchronous mode
  assign os_max = (pcr_q[PCR_DBL_BIT] & ~sync_mode) ?
                  OS_DBL_MAX : OS_NORM_MAX;
  assign os_mid = (pcr_q[PCR_DBL_BIT] & ~sync_mode) ?
                  OS_DBL_MID : OS_NORM_MID;

  ufbc_baud_gen u_baud (
    .clk_i     (CLK_I),
    .rstn_i    (RSTN_I),
    .divisor_i (reload ? {bdh_q, PWDATA_I[7:0]} : {bdh_q, bdl_q}),
    .reload_i  (reload),
    .tick_o    (tick)
  );

  // ---------------- transfer clock ----------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      xck_q    <= 1'b0;
      XCK_OE_O <= 1'b0;
    end else begin
      XCK_OE_O <= sync_mode;
      if (!sync_mode) begin
        xck_q <= 1'b0;
      end else if (tick) begin
        xck_q <= ~xck_q;
      end
    end
  end
  assign XCK_O = xck_q;

  // launch edge is rising for polarity 0, falling for polarity 1
  assign launch = sync_mode & tick & (xck_q == ffc_q[FFC_POL_BIT]);
  assign sample = sync_mode & tick & (xck_q != ffc_q[FFC_POL_BIT]);

  assign tx_bit  = sync_mode ? launch : (tick & (tx_cnt_q == os_max));
  assign rx_samp = sync_mode ? sample : (tick & (rx_cnt_q == os_mid));
  assign rx_go   = pcr_q[PCR_RX_EN_BIT] & ~RXD_I &
                   (sync_mode ? sample : tick);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_cnt_q <= 4'h0;
      rx_cnt_q <= 4'h0;
    end else begin
      if (tx_st_q == UFBC_TX_IDLE) begin
        tx_cnt_q <= 4'h0;
      end else if (tick) begin
        tx_cnt_q <= (tx_cnt_q == os_max) ? 4'h0 : tx_cnt_q + 4'h1;
      end
      if (rx_st_q == UFBC_RX_IDLE) begin
        rx_cnt_q <= 4'h0;
      end else if (tick) begin
        rx_cnt_q <= (rx_cnt_q == os_max) ? 4'h0 : rx_cnt_q + 4'h1;
      end
    end
  end

  // ---------------- transmitter ----------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_st_q   <= UFBC_TX_IDLE;
      tx_sh_q   <= 9'h000;
      tx_par_q  <= 1'b0;
      tx_idx_q  <= 4'h0;
      tx_stop_q <= 1'b0;
      tx_done_q <= 1'b0;
      TXD_O     <= 1'b1;
    end else begin
      tx_done_q <= 1'b0;
      case (tx_st_q)
        UFBC_TX_IDLE: begin
          TXD_O <= 1'b1;
          if (tx_load) begin
            tx_sh_q  <= PWDATA_I[8:0] & ufbc_mask(nbits);
            tx_par_q <= par_odd ^
                        (^(PWDATA_I[8:0] & ufbc_mask(nbits)));
            tx_st_q  <= UFBC_TX_WAIT;
          end
        end
        UFBC_TX_WAIT: begin
          if (tx_bit) begin
            TXD_O   <= 1'b0;
            tx_st_q <= UFBC_TX_START;
          end
        end
        UFBC_TX_START: begin
          if (tx_bit) begin
            TXD_O    <= tx_sh_q[0];
            tx_sh_q  <= tx_sh_q >> 1;
            tx_idx_q <= 4'h1;
            tx_st_q  <= UFBC_TX_DATA;
          end
        end
        UFBC_TX_DATA: begin
          if (tx_bit) begin
            if (tx_idx_q == nbits) begin
              if (par_on) begin
                TXD_O   <= tx_par_q;
                tx_st_q <= UFBC_TX_PAR;
              end else begin
                TXD_O     <= 1'b1;
                tx_stop_q <= 1'b0;
                tx_st_q   <= UFBC_TX_STOP;
              end
            end else begin
              TXD_O    <= tx_sh_q[0];
              tx_sh_q  <= tx_sh_q >> 1;
              tx_idx_q <= tx_idx_q + 4'h1;
            end
          end
        end
        UFBC_TX_PAR: begin
          if (tx_bit) begin
            TXD_O     <= 1'b1;
            tx_stop_q <= 1'b0;
            tx_st_q   <= UFBC_TX_STOP;
          end
        end
        UFBC_TX_STOP: begin
          if (tx_bit) begin
            if (stop2 && !tx_stop_q) begin
              tx_stop_q <= 1'b1;
            end else begin
              tx_st_q   <= UFBC_TX_IDLE;
              tx_done_q <= 1'b1;
            end
          end
        end
        default: tx_st_q <= UFBC_TX_IDLE;
      endcase
    end
  end

  // ---------------- receiver ----------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_st_q   <= UFBC_RX_IDLE;
      rx_sh_q   <= 9'h000;
      rx_par_q  <= 1'b0;
      rx_idx_q  <= 4'h0;
      rx_done_q <= 1'b0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
      rx_data_q <= 9'h000;
    end else begin
      rx_done_q <= 1'b0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
      case (rx_st_q)
        UFBC_RX_IDLE: begin
          rx_sh_q  <= 9'h000;
          rx_par_q <= 1'b0;
          rx_idx_q <= 4'h0;
          if (rx_go) begin
            rx_st_q <= sync_mode ? UFBC_RX_DATA : UFBC_RX_START;
          end
        end
        UFBC_RX_START: begin
          if (rx_samp) begin
            rx_st_q <= RXD_I ? UFBC_RX_IDLE : UFBC_RX_DATA;
          end
        end
        UFBC_RX_DATA: begin
          if (rx_samp) begin
            rx_sh_q  <= {RXD_I, rx_sh_q[8:1]};
            rx_par_q <= rx_par_q ^ RXD_I;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits - 4'h1) begin
              rx_st_q <= par_on ? UFBC_RX_PAR : UFBC_RX_STOP;
            end
          end
        end
        UFBC_RX_PAR: begin
          if (rx_samp) begin
            rx_par_q <= rx_par_q ^ RXD_I;
            rx_st_q  <= UFBC_RX_STOP;
          end
        end
        UFBC_RX_STOP: begin
          // only the first stop bit is checked, whatever stop2 says
          if (rx_samp) begin
            rx_st_q   <= UFBC_RX_IDLE;
            rx_done_q <= 1'b1;
            rx_data_q <= rx_sh_q >> (MAX_BITS - nbits);
            perr_q    <= par_on & (rx_par_q != par_odd);
            ferr_q    <= ~RXD_I;
          end
        end
        default: rx_st_q <= UFBC_RX_IDLE;
      endcase
    end
  end

  // ---------------- interrupts ----------------
  always_comb begin
    ev              = '0;
    ev[IRQ_TX_DONE] = tx_done_q;
    ev[IRQ_RX_DONE] = rx_done_q;
    ev[IRQ_PAR_ERR] = perr_q;
    ev[IRQ_FRM_ERR] = ferr_q;
  end

  // a set in the clearing cycle wins
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stat_q   <= '0;
      irq_en_q <= '0;
      IRQ_O    <= 1'b0;
    end else begin
      if (wr && PADDR_I == OFS_IRQ_CLR) begin
        stat_q <= (stat_q & ~PWDATA_I[IRQ_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      if (wr && PADDR_I == OFS_IRQ_EN) begin
        irq_en_q <= PWDATA_I[IRQ_W-1:0];
      end
      IRQ_O <= |(stat_q & irq_en_q);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_last_stop;
    (tx_st_q == UFBC_TX_STOP) && tx_bit && (!stop2 || tx_stop_q);
  endsequence

  a_async_clock_still: assert property (
    !sync_mode |=> !XCK_O && !XCK_OE_O)
    else $error("transfer clock active in async mode");

  a_parity_bit_out: assert property (
    (tx_st_q == UFBC_TX_DATA && tx_bit && tx_idx_q == nbits && par_on)
    |=> (TXD_O == tx_par_q) && (tx_st_q == UFBC_TX_PAR))
    else $error("parity bit not inserted");

  a_stop_count: assert property (
    ((tx_st_q == UFBC_TX_STOP) && tx_bit && stop2 && !tx_stop_q)
    |=> (tx_st_q == UFBC_TX_STOP) && TXD_O)
    else $error("second stop bit missing");

  a_stop_end: assert property (
    s_last_stop |=> (tx_st_q == UFBC_TX_IDLE) && tx_done_q)
    else $error("frame did not end after stop bits");

  a_parity_flag: assert property (
    (rx_st_q == UFBC_RX_STOP && rx_samp && par_on &&
     rx_par_q != par_odd) |=> perr_q ##1 stat_q[IRQ_PAR_ERR])
    else $error("parity error not flagged");

  a_char_size: assert property (
    (rx_st_q == UFBC_RX_DATA && rx_samp && rx_idx_q == nbits - 4'h1)
    |=> rx_st_q != UFBC_RX_DATA)
    else $error("receiver bit count wrong");

  a_sync_launch: assert property (
    (sync_mode && $past(sync_mode) && $changed(TXD_O) &&
     $past(tx_st_q) != UFBC_TX_IDLE) |-> $past(launch))
    else $error("sync data changed off the launch edge");

  a_rx_upper_zero: assert property (
    rx_done_q |-> (rx_data_q & ~ufbc_mask(nbits)) == 9'h000)
    else $error("unused receive bits not zero");

  a_double_speed: assert property (
    (!sync_mode && pcr_q[PCR_DBL_BIT] && tx_bit) |-> tx_cnt_q == 4'h7)
    else $error("double speed does not divide by 8");

endmodule : ufbc_core

// File: dv/ufbc_remote_model.sv
// ufbc_remote_model: far-end serial transceiver for the frame bench.
// assumes the system clock and a bit length given in clocks.
`timescale 1ns/1ns
module ufbc_remote_model (
  // clock, bit timing and frame shape
  input  wire logic        clk_i,
  input  wire logic [15:0] bit_clks_i,
  input  wire logic [3:0]  nbits_i,
  input  wire logic        par_on_i,
  // serial lines
  input  wire logic        txd_i,
  output logic             rxd_o,
  // captured frame
  output logic [8:0]       data_o,
  output logic             parb_o,
  output logic [15:0]      low_o,
  output int unsigned      cyc_o,
  output int unsigned      start_o
);
  initial begin
    rxd_o = 1'b1;
  end
  always @(posedge clk_i) cyc_o <= cyc_o + 1;
  // samples each bit in its middle; data bit 0 must be 1
  always begin
    @(negedge txd_i);
    start_o = cyc_o;
    low_o = '0;
    data_o = '0;
    @(posedge clk_i);
    while (txd_i === 1'b0) begin
      low_o++;
      @(posedge clk_i);
    end
    repeat (bit_clks_i / 2 - 1) @(posedge clk_i);
    for (int i = 0; i < nbits_i; i++) begin
      data_o[i] = txd_i;
      repeat (bit_clks_i) @(posedge clk_i);
    end
    parb_o = txd_i;
  end
  task automatic send(input logic [8:0] d, input logic [3:0] n,
                      input logic pb, input logic [15:0] bc);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (bc) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= d[i];
      repeat (bc) @(posedge clk_i);
    end
    if (par_on_i) begin
      rxd_o <= pb;
      repeat (bc) @(posedge clk_i);
    end
    // one stop bit whatever the stop select says
    rxd_o <= 1'b1;
    repeat (bc) @(posedge clk_i);
  endtask : send
endmodule : ufbc_remote_model

// File: dv/ufbc_core_tb.sv
// ufbc_core_tb: self-checking bench for the frame and baud block.
// assumes ufbc_pkg offsets and the remote model on the serial pins.
`timescale 1ns/1ns
module ufbc_core_tb;
  import ufbc_pkg::*;
  typedef struct {
    logic [7:0] ffc;
    logic [7:0] pcr;
    logic [8:0] dat;
    logic [3:0] n;
  } ufbc_row_type;
  // async rows keep polarity zero
  ufbc_row_type rows [5] = '{
    '{8'h20, 8'h0C, 9'h1F5, 4'h5},
    '{8'h3A, 8'h0C, 9'h0C3, 4'h6},
    '{8'h04, 8'h0D, 9'h1FF, 4'h7},
    '{8'h1E, 8'h0C, 9'h0A5, 4'h8},
    '{8'h26, 8'h0E, 9'h155, 4'h9}};
  logic [7:0]  ra [5] = '{OFS_FRAME_FMT, OFS_BAUD_HIGH, OFS_BAUD_LOW,
                          OFS_PORT_CTRL, OFS_IRQ_EN};
  logic [7:0]  rv [5] = '{8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        CLK_I = 1'b0;
  logic        RSTN_I = 1'b0;
  logic        PSEL_I = 1'b0;
  logic        PENABLE_I = 1'b0;
  logic        PWRITE_I = 1'b0;
  logic [7:0]  PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0;
  logic [31:0] PRDATA_O;
  logic        PREADY_O;
  logic        PSLVERR_O;
  logic        RXD_I;
  logic        TXD_O;
  logic        XCK_O;
  logic        XCK_OE_O;
  logic        IRQ_O;
  logic [15:0] bc = 16'd32;
  logic [3:0]  nb = 4'h8;
  logic        pon = 1'b0;
  logic [8:0]  cdat;
  logic        cpar;
  logic [15:0] low;
  int unsigned cyc;
  int unsigned st;
  logic [31:0] rdat;
  logic        rerr;
  logic [8:0]  md;
  logic        prev;
  int          el;
  int          fl;
  int          miscompares = 0;
  int          checked = 0;
  always #50 CLK_I = ~CLK_I;
  ufbc_core DUT (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .RXD_I(RXD_I), .TXD_O(TXD_O), .XCK_O(XCK_O),
    .XCK_OE_O(XCK_OE_O), .IRQ_O(IRQ_O));
  ufbc_remote_model remote (.clk_i(CLK_I), .bit_clks_i(bc), .nbits_i(nb),
    .par_on_i(pon), .txd_i(TXD_O), .rxd_o(RXD_I), .data_o(cdat),
    .parb_o(cpar), .low_o(low), .cyc_o(cyc), .start_o(st));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= wd;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    @(posedge CLK_I);
    while (PREADY_O !== 1'b1) @(posedge CLK_I);
    rdat = PRDATA_O;
    rerr = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask : apb
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge CLK_I);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    // divisor is only changed while the line is quiet
    apb(1'b1, OFS_BAUD_HIGH, 32'h0);
    apb(1'b1, OFS_BAUD_LOW, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    foreach (rows[i]) begin
      bc = rows[i].pcr[PCR_DBL_BIT] ? 16'd16 : 16'd32;
      nb = rows[i].n;
      pon = rows[i].ffc[FFC_PAR_EN_BIT];
      md = rows[i].dat & ((9'h1 << rows[i].n) - 9'h1);
      fl = (2 + rows[i].n + pon + rows[i].ffc[FFC_STOP_BIT]) * bc;
      apb(1'b1, OFS_FRAME_FMT, {24'h0, rows[i].ffc});
      apb(1'b1, OFS_PORT_CTRL, {24'h0, rows[i].pcr});
      apb(1'b1, OFS_TX_DATA, {23'h0, rows[i].dat});
      while (IRQ_O !== 1'b1) @(posedge CLK_I);
      el = cyc - st;
      chk("tx data", cdat, md);
      chk("bit length", low, bc);
      if (pon) chk("tx parity", cpar, ^md ^ rows[i].ffc[4]);
      chk("frame length", el + bc / 2 > fl && el < fl + bc / 2, 1);
      apb(1'b1, OFS_IRQ_CLR, 32'hF);
    end
    // receive: wrong parity with one stop while two are selected
    apb(1'b1, OFS_FRAME_FMT, 32'h2E);
    apb(1'b1, OFS_PORT_CTRL, 32'h08);
    apb(1'b1, OFS_IRQ_EN, 32'h4);
    bc = 16'd32;
    pon = 1'b1;
    remote.send(9'h0A5, 4'h8, 1'b1, 16'd32);
    while (IRQ_O !== 1'b1) @(posedge CLK_I);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("parity flag", rdat[IRQ_PAR_ERR], 1);
    apb(1'b0, OFS_RX_DATA, 32'h0);
    chk("rx data", rdat, 32'hA5);
    apb(1'b1, OFS_IRQ_CLR, 32'hF);
    apb(1'b1, OFS_FRAME_FMT, 32'h0);
    pon = 1'b0;
    remote.send(9'h015, 4'h5, 1'b0, 16'd32);
    do apb(1'b0, OFS_IRQ_STAT, 32'h0);
    while (rdat[IRQ_RX_DONE] !== 1'b1);
    chk("parity flag", rdat[IRQ_PAR_ERR], 0);
    chk("masked irq", IRQ_O, 0);
    apb(1'b0, OFS_RX_DATA, 32'h0);
    chk("rx short", rdat, 32'h15);
    // synchronous transmit, both clock polarities
    apb(1'b1, OFS_PORT_CTRL, 32'h04);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, OFS_FRAME_FMT, 32'h46 | p);
      apb(1'b1, OFS_TX_DATA, 32'h0A5);
      prev = TXD_O;
      repeat (200) begin
        @(posedge CLK_I);
        if (TXD_O !== prev) chk("launch edge", XCK_O, p == 0);
        prev = TXD_O;
      end
      chk("xck drive", XCK_OE_O, 1);
    end
    // synchronous receive: one bit per transfer clock period
    apb(1'b1, OFS_PORT_CTRL, 32'h08);
    remote.send(9'h05A, 4'h8, 1'b0, 16'd4);
    apb(1'b0, OFS_RX_DATA, 32'h0);
    chk("sync rx", rdat, 32'h5A);
    // second reset in mid-run, then register values
    RSTN_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    chk("tx idle", TXD_O, 1);
    chk("xck drive", XCK_OE_O, 0);
    chk("irq", IRQ_O, 0);
    RSTN_I <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rdat, {24'h0, rv[i]});
    end
    apb(1'b1, OFS_FRAME_FMT, 32'h86);
    apb(1'b0, OFS_FRAME_FMT, 32'h0);
    chk("format bit 7", rdat, 32'h06);
    apb(1'b1, OFS_BAUD_HIGH, 32'h0A);
    apb(1'b1, OFS_BAUD_LOW, 32'h5B);
    apb(1'b0, OFS_BAUD_HIGH, 32'h0);
    chk("divisor high", rdat, 32'h0A);
    apb(1'b0, OFS_BAUD_LOW, 32'h0);
    chk("divisor low", rdat, 32'h5B);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped error", rerr, 1);
    chk("unmapped data", rdat, 32'h0);
    // divisor 3: low write reloads at once, then 64 clocks per bit
    apb(1'b1, OFS_BAUD_HIGH, 32'h0);
    apb(1'b1, OFS_BAUD_LOW, 32'h3);
    apb(1'b1, OFS_PORT_CTRL, 32'h04);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    bc = 16'd64;
    nb = 4'h8;
    pon = 1'b0;
    apb(1'b1, OFS_TX_DATA, 32'h0A5);
    while (IRQ_O !== 1'b1) @(posedge CLK_I);
    chk("slow tx data", cdat, 32'hA5);
    chk("slow bit length", low, 32'd64);
    end_sim();
  end
endmodule : ufbc_core_tb
